// ===== io_watchdog_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "io_watchdog_map.vh"

// Notes on behaviour
// - Units bit: zero minutes, one seconds.
// - Zero timeout value disables counting timeouts.
// - Timeout value is binary count, up to 255.
// - Joystick enable: port 201h access restarts.
// - Keyboard enable: keyboard interrupt restarts.
// - Mouse enable: mouse interrupt restarts.
// - Config bits 7:4 route interrupt line.
// - Status bit set on timeout, read/write.
// - Writing force bit causes timeout, self-clears.
// - External enable lets controller rising edge force.
// - Edge pulse ORed with software force bit.
module io_watchdog_timer #(
    parameter [31:0] SECOND_CYCLES = `WD_CLK_HZ * `WD_SECOND_S,
    parameter [31:0] MINUTE_SECONDS = `WD_MINUTE_S
) (
    input wire core_clk, // System clock, 10 MHz.
    input wire rst, // Main power-on reset, async, active high.
    input wire standbyPor, // Standby supply power-on reset pin.
    input wire busReset, // Host bus reset pin.
    input wire [7:0] address, // Avalon word address.
    input wire read, // Avalon read strobe.
    input wire write, // Avalon write strobe.
    input wire [31:0] writedata, // Avalon write data.
    input wire [3:0] byteenable, // Avalon byte enables.
    output reg [31:0] readdata, // Avalon read data.
    output wire waitrequest, // Avalon wait request.
    input wire ioStrobe, // Pulse on any host I/O cycle, same clock.
    input wire [15:0] ioAddr, // Host I/O address with ioStrobe.
    input wire kbdIrq, // Keyboard interrupt level pin.
    input wire mouseIrq, // Mouse interrupt level pin.
    input wire kbcForceOutput, // Keyboard controller forcing output pin.
    output reg [15:0] irqLines // Host interrupt lines, one-hot.
);

    // Host-visible register copies and timer state.
    reg [7:0] unitsReg_q;
    reg [7:0] countReg_q;
    reg [7:0] config_q;
    reg statusBit_q;
    reg extEnable_q;
    reg forceBit_q;
    reg [7:0] remain_q;
    reg [31:0] tick_q;
    reg [5:0] minuteCnt_q;
    reg ack_q;
    // Synchronisers and edge detector history.
    reg [1:0] standbySync_q;
    reg [1:0] busSync_q;
    reg [1:0] kbcSync_q;
    reg [1:0] kbdSync_q;
    reg [1:0] mouseSync_q;
    reg kbcLast_q;
    reg kbdLast_q;
    reg mouseLast_q;
    // Decoded strobes and events.
    wire standbyRst;
    wire busRst;
    wire wrStb;
    wire rdStb;
    wire kbcRise;
    wire kbdRise;
    wire mouseRise;
    wire joyHit;
    wire restart;
    wire secondTick;
    wire unitTick;
    wire countTimeout;
    wire timeoutEvent;
    wire localReset;
    wire wrUnits;
    wire wrCount;
    wire wrConfig;
    wire wrControl;
    wire loadCount;

    // Standby reset pin passes two flip-flops before any logic reads it.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            standbySync_q <= 2'h0;
        end else begin
            standbySync_q <= {standbySync_q[0], standbyPor};
        end
    end

    // Bus reset pin is synchronised the same way.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busSync_q <= 2'h0;
        end else begin
            busSync_q <= {busSync_q[0], busReset};
        end
    end

    // Forcing output pin synchroniser.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            kbcSync_q <= 2'h0;
        end else begin
            kbcSync_q <= {kbcSync_q[0], kbcForceOutput};
        end
    end

    // Keyboard interrupt pin synchroniser.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            kbdSync_q <= 2'h0;
        end else begin
            kbdSync_q <= {kbdSync_q[0], kbdIrq};
        end
    end

    // Mouse interrupt pin synchroniser.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mouseSync_q <= 2'h0;
        end else begin
            mouseSync_q <= {mouseSync_q[0], mouseIrq};
        end
    end

    // Edge detectors look only at the second synchroniser stage.
    // History resets to the pins' idle low level, so no false edge.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            kbcLast_q <= 1'b0;
        end else begin
            kbcLast_q <= kbcSync_q[1];
        end
    end

    // Keyboard interrupt history for its edge detector.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            kbdLast_q <= 1'b0;
        end else begin
            kbdLast_q <= kbdSync_q[1];
        end
    end

    // Mouse interrupt history for its edge detector.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mouseLast_q <= 1'b0;
        end else begin
            mouseLast_q <= mouseSync_q[1];
        end
    end

    assign standbyRst = standbySync_q[1];
    assign busRst = busSync_q[1];
    // A held-high output gives one pulse only, so a long level is safe.
    assign kbcRise = kbcSync_q[1] & ~kbcLast_q;
    assign kbdRise = kbdSync_q[1] & ~kbdLast_q;
    assign mouseRise = mouseSync_q[1] & ~mouseLast_q;

    // Registers answer after one wait cycle: waitrequest drops while acking.
    assign waitrequest = (read | write) & ~ack_q;
    assign wrStb = write & ack_q;
    assign rdStb = read & ~ack_q;

    // Restart sources, each gated by its own enable bit.
    assign joyHit = ioStrobe && (ioAddr == `WD_JOY_PORT);
    assign restart = (joyHit & config_q[`WD_CFG_JOY_BIT])
        | (kbdRise & config_q[`WD_CFG_KBD_BIT])
        | (mouseRise & config_q[`WD_CFG_MOUSE_BIT]);

    // Unit pacing: one second of cycles, then sixty for a minute.
    assign secondTick = (tick_q == SECOND_CYCLES - 32'h1);
    assign unitTick = secondTick
        & (unitsReg_q[`WD_UNITS_SEC_BIT] |
           ({26'h0, minuteCnt_q} == MINUTE_SECONDS - 32'h1));
    // A zero remaining count never times out by counting.
    assign countTimeout = unitTick && (remain_q == 8'h01)
        && (countReg_q != 8'h00);
    assign timeoutEvent = countTimeout | forceBit_q
        | (kbcRise & extEnable_q);

    // Bus handshake: one wait cycle, then ack for one cycle.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    // Read data is registered in the wait cycle.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0;
        end else if (rdStb) begin
            if (address == `WD_IDX_UNITS) begin
                readdata <= {24'h0, unitsReg_q};
            end else if (address == `WD_IDX_COUNT) begin
                readdata <= {24'h0, countReg_q};
            end else if (address == `WD_IDX_CONFIG) begin
                readdata <= {24'h0, config_q};
            end else if (address == `WD_IDX_CONTROL) begin
                // Force bit is write-only and reads as zero.
                readdata <= {28'h0, extEnable_q, 2'h0, statusBit_q};
            end else begin
                readdata <= 32'h0;
            end
        end
    end

    // Write selects need byteenable[0]; writes without it are refused.
    assign wrUnits = wrStb && byteenable[0] && address == `WD_IDX_UNITS;
    assign wrCount = wrStb && byteenable[0] && address == `WD_IDX_COUNT;
    assign wrConfig = wrStb && byteenable[0] && address == `WD_IDX_CONFIG;
    assign wrControl = wrStb && byteenable[0]
        && address == `WD_IDX_CONTROL;
    // Either synchronised reset pin clears everything but status, which only standby clears.
    assign localReset = standbyRst | busRst;

    // Units register keeps only the seconds select bit.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            unitsReg_q <= `WD_RESET_VAL;
        end else if (localReset) begin
            unitsReg_q <= `WD_RESET_VAL;
        end else if (wrUnits) begin
            unitsReg_q <= writedata[7:0] & 8'h80;
        end
    end

    // Timeout value, a plain binary count of units.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            countReg_q <= `WD_RESET_VAL;
        end else if (localReset) begin
            countReg_q <= `WD_RESET_VAL;
        end else if (wrCount) begin
            countReg_q <= writedata[7:0];
        end
    end

    // Configuration; the reserved bit 3 always reads zero.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            config_q <= `WD_RESET_VAL;
        end else if (localReset) begin
            config_q <= `WD_RESET_VAL;
        end else if (wrConfig) begin
            config_q <= writedata[7:0] & 8'hf7;
        end
    end

    // External force enable; a bus reset clears it as well.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            extEnable_q <= 1'b0;
        end else if (localReset) begin
            extEnable_q <= 1'b0;
        end else if (wrControl) begin
            extEnable_q <= writedata[`WD_CTL_EXTEN_BIT];
        end
    end

    // Force lives one cycle only, so it clears itself.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            forceBit_q <= 1'b0;
        end else if (localReset) begin
            forceBit_q <= 1'b0;
        end else if (wrControl) begin
            forceBit_q <= writedata[`WD_CTL_FORCE_BIT];
        end else begin
            forceBit_q <= 1'b0;
        end
    end

    // Status survives bus reset; a new timeout beats a software clear.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            statusBit_q <= 1'b0;
        end else if (standbyRst) begin
            statusBit_q <= 1'b0;
        end else if (timeoutEvent) begin
            statusBit_q <= 1'b1;
        end else if (wrStb && byteenable[0]
                     && address == `WD_IDX_CONTROL) begin
            statusBit_q <= writedata[`WD_CTL_STATUS_BIT];
        end
    end

    // A count write or an enabled restart reloads and realigns units.
    assign loadCount = restart | wrCount;

    // Remaining units; counting stops at zero.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            remain_q <= 8'h00;
        end else if (localReset) begin
            remain_q <= 8'h00;
        end else if (loadCount) begin
            remain_q <= restart ? countReg_q : writedata[7:0];
        end else if (unitTick && remain_q != 8'h00) begin
            remain_q <= remain_q - 8'h01;
        end
    end

    // Cycles within one second; idle while nothing counts.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_q <= 32'h0;
        end else if (localReset | loadCount) begin
            tick_q <= 32'h0;
        end else if (remain_q != 8'h00) begin
            tick_q <= secondTick ? 32'h0 : tick_q + 32'h1;
        end
    end

    // Seconds within a minute; a unit tick starts the next minute.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            minuteCnt_q <= 6'h0;
        end else if (localReset | loadCount) begin
            minuteCnt_q <= 6'h0;
        end else if (remain_q != 8'h00 && secondTick) begin
            minuteCnt_q <= unitTick ? 6'h0 : minuteCnt_q + 6'h1;
        end
    end

    // Interrupt line follows the status bit on the routed line.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irqLines <= 16'h0;
        end else begin
            irqLines <= 16'h0;
            if (config_q[7:4] != 4'h0 && config_q[7:4] != `WD_IRQ_INVALID)
            begin
                irqLines[config_q[7:4]] <= statusBit_q;
            end
        end
    end

endmodule
`default_nettype wire

// ===== io_watchdog_map.vh
`ifndef IO_WATCHDOG_MAP_VH
`define IO_WATCHDOG_MAP_VH
// Register word indices; byte address is four times the index.
`define WD_IDX_UNITS 8'h52
`define WD_IDX_COUNT 8'h53
`define WD_IDX_CONFIG 8'h54
`define WD_IDX_CONTROL 8'h55
// Field positions.
`define WD_UNITS_SEC_BIT 7
`define WD_CFG_JOY_BIT 0
`define WD_CFG_KBD_BIT 1
`define WD_CFG_MOUSE_BIT 2
`define WD_CFG_IRQ_LSB 4
`define WD_CTL_STATUS_BIT 0
`define WD_CTL_FORCE_BIT 2
`define WD_CTL_EXTEN_BIT 3
// Reset value; interrupt route that is never driven.
`define WD_RESET_VAL 8'h00
`define WD_IRQ_INVALID 4'h2
// Timing: clock rate and unit lengths; joystick port address.
`define WD_CLK_HZ 10000000
`define WD_SECOND_S 1
`define WD_MINUTE_S 60
`define WD_JOY_PORT 16'h0201
`endif

// ===== io_watchdog_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module io_watchdog_timer_asserts (
    input wire logic core_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic [7:0] address, // Word index.
    input wire logic read, // Read strobe.
    input wire logic write, // Write strobe.
    input wire logic [31:0] readdata, // Read data.
    input wire logic waitrequest, // Stall.
    input wire logic [15:0] irqLines // Interrupt lines.
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_WAIT_FIRST: assert property (($rose(read) || $rose(write)) |->
        waitrequest) else $error("first cycle not stalled");
    AST_WAIT_ONE: assert property ((read || write) && waitrequest |=>
        !waitrequest) else $error("stall longer than one cycle");
    AST_RD_UPPER: assert property (read && !waitrequest |->
        readdata[31:8] == 24'h0) else $error("upper read bits set");
    AST_RD_HOLE: assert property (read && !waitrequest && (address < 8'h52
        || address > 8'h55) |-> readdata == 32'h0) else $error("hole read");
    AST_FORCE_RD: assert property (
        read && !waitrequest && address == 8'h55 |-> !readdata[2])
        else $error("force bit reads back");
    AST_IRQ_ONE: assert property ($onehot0(irqLines))
        else $error("more than one line");
    AST_IRQ_BAD: assert property (!irqLines[0] && !irqLines[2])
        else $error("line 0 or 2 driven");
    AST_RST_IRQ: assert property ($fell(rst) |-> irqLines == 16'h0)
        else $error("line up after reset");
endmodule
bind io_watchdog_timer io_watchdog_timer_asserts u_chk (.core_clk, .rst,
    .address, .read, .write, .readdata, .waitrequest, .irqLines);
`default_nettype wire

// ===== kbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: a kick raises a pin for HOLD cycles, never less than 1us.
module kbc_host_model #(
    parameter int HOLD = 12
) (
    input wire logic core_clk, // Clock.
    input wire logic [2:0] kick, // Kick per pin: keyboard, mouse, force.
    output var logic kbdIrq, // Keyboard interrupt.
    output var logic mouseIrq, // Mouse interrupt.
    output var logic kbcForceOutput // Forcing output.
);
    logic [4:0] holdCnt_q [3] = '{default: 5'h0};
    // A kick restarts the hold count, so only a fresh rise is an event.
    always @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (kick[i]) begin
                holdCnt_q[i] <= 5'(HOLD);
            end else if (holdCnt_q[i] != 5'h0) begin
                holdCnt_q[i] <= holdCnt_q[i] - 5'h1;
            end
        end
    end
    // Pins are high while their count runs.
    assign kbdIrq = holdCnt_q[0] != 5'h0;
    assign mouseIrq = holdCnt_q[1] != 5'h0;
    assign kbcForceOutput = holdCnt_q[2] != 5'h0;
endmodule
`default_nettype wire

// ===== io_watchdog_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_watchdog_map.vh"
module io_watchdog_timer_bench;
    logic core_clk = 0, rst = 1, standbyPor = 0, busReset = 0;
    logic read = 0, write = 0, ioStrobe = 0;
    logic [7:0] address = 0;
    logic [31:0] writedata = 0;
    logic [3:0] byteenable = 4'h1;
    logic [15:0] ioAddr = 0;
    logic [2:0] kick = 0;
    logic [3:0] r;
    wire [31:0] readdata;
    wire [15:0] irqLines;
    wire waitrequest, kbdIrq, mouseIrq, kbcOut;
    int error_cnt = 0, total_checks = 0;
    logic [31:0] expQ [$];
    // Short units keep the run brief: a second is 10 cycles, a minute 30.
    io_watchdog_timer #(.SECOND_CYCLES(32'd10), .MINUTE_SECONDS(32'd3))
        u_dut (.core_clk, .rst, .standbyPor, .busReset, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest, .ioStrobe,
        .ioAddr, .kbdIrq, .mouseIrq, .kbcForceOutput(kbcOut), .irqLines);
    kbc_host_model u_kbc (.core_clk, .kick, .kbdIrq, .mouseIrq,
        .kbcForceOutput(kbcOut));
    always #50 core_clk = ~core_clk;
    task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmpIrq(logic [15:0] e);
        cmp("irqLines", {16'h0, e}, {16'h0, irqLines});
    endtask
    // Request holds until waitrequest is sampled low at a rising edge.
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        do begin
            @(posedge core_clk);
        end while (waitrequest);
        read <= 0;
        write <= 0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1, a, d);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        expQ.push_back(e);
        bus(0, a, 0);
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Source 0 is a port access, 1 to 3 kick the partner's pins.
    task automatic poke(int s);
        @(posedge core_clk);
        ioAddr <= (s == 0) ? `WD_JOY_PORT : 16'($urandom);
        ioStrobe <= 1;
        kick <= 3'((1 << s) >> 1);
        @(posedge core_clk);
        ioStrobe <= 0;
        kick <= 0;
    endtask
    // Read results are matched to notes in the order they were made.
    always @(posedge core_clk) begin
        if (read && !waitrequest) begin
            cmp("readdata", expQ.size() ? expQ.pop_front() : 32'hx, readdata);
        end
    end
    task automatic end_sim;
        $display("Checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #3000000;
        error_cnt++;
        end_sim;
    end
    initial begin
        void'($urandom(32'h2fcd28da));
        repeat (4) @(posedge core_clk);
        rst <= 0;
        for (int a = 8'h52; a <= 8'h56; a++) rd(8'(a), 0);
        for (int c = 0; c < 16; c++) begin
            wr(`WD_IDX_CONFIG, c << 4);
            wr(`WD_IDX_CONTROL, 32'h4);
            cyc(4);
            cmpIrq((c == 0 || c == 2) ? 16'h0 : 16'(1 << c));
            wr(`WD_IDX_CONTROL, 0);
            cyc(2);
            cmpIrq(0);
        end
        wr(`WD_IDX_UNITS, 32'h80);
        wr(`WD_IDX_COUNT, 3);
        rd(`WD_IDX_CONTROL, 0);
        cyc(12);
        cmpIrq(0);
        cyc(20);
        cmpIrq(16'h8000);
        rd(`WD_IDX_CONTROL, 1);
        wr(`WD_IDX_COUNT, 0);
        wr(`WD_IDX_CONTROL, 0);
        wr(`WD_IDX_UNITS, 0);
        wr(`WD_IDX_COUNT, 2);
        cyc(27);
        cmpIrq(0);
        cyc(40);
        cmpIrq(16'h8000);
        wr(`WD_IDX_UNITS, 32'h80);
        wr(`WD_IDX_COUNT, 0);
        wr(`WD_IDX_CONTROL, 0);
        cyc(40);
        cmpIrq(0);
        for (int s = 0; s < 6; s++) begin
            r = 4'($urandom_range(15, 3));
            wr(`WD_IDX_CONFIG, {r, 4'h0} | ((s < 3) << (s % 3)));
            wr(`WD_IDX_COUNT, 3);
            cyc(15);
            poke(s % 3);
            cyc(19);
            cmpIrq(s < 3 ? 16'h0 : 16'(1 << r));
            cyc(20);
            cmpIrq(16'(1 << r));
            wr(`WD_IDX_COUNT, 0);
            wr(`WD_IDX_CONTROL, 0);
        end
        wr(`WD_IDX_CONFIG, 32'h50);
        poke(3);
        cyc(20);
        cmpIrq(0);
        wr(`WD_IDX_CONTROL, 32'h8);
        poke(3);
        cyc(8);
        cmpIrq(16'h20);
        rd(`WD_IDX_CONTROL, 32'h9);
        @(posedge core_clk);
        busReset <= 1;
        repeat (4) @(posedge core_clk);
        busReset <= 0;
        cyc(4);
        rd(`WD_IDX_CONTROL, 1);
        rd(`WD_IDX_CONFIG, 0);
        cmpIrq(0);
        @(posedge core_clk);
        standbyPor <= 1;
        repeat (4) @(posedge core_clk);
        standbyPor <= 0;
        cyc(4);
        rd(`WD_IDX_CONTROL, 0);
        end_sim;
    end
endmodule
`default_nettype wire
